// ### core/drive_protection_monitor_regs.vh
// Register map, field layout, reset values and timing for the monitor.
`ifndef DRIVE_PROTECTION_MONITOR_REGS_VH
`define DRIVE_PROTECTION_MONITOR_REGS_VH
`define ADDR_CTRL 8'h00
`define ADDR_LEVEL 8'h04
`define ADDR_TIME1 8'h08
`define ADDR_FAN_DELAY 8'h0C
`define ADDR_AMBIENT 8'h10
`define ADDR_TERMINALS 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_DERATE 8'h1C
`define CTRL_INIT_RST 32'h0000_0000
`define LEVEL_RST 32'h0000_9696
`define TIME1_RST 32'h0000_0001
`define FAN_DELAY_RST 32'h0000_003C
`define AMBIENT_RST 32'h0000_0028
`define TERMINALS_RST 32'h0000_0000
`define CTRL_TSEL 3:0
`define CTRL_IPL_EN 4
`define CTRL_OPL_SEL 6:5
`define CTRL_GF_EN 7
`define CTRL_FAN_MODE 9:8
`define CTRL_INSTALL 11:10
`define CTRL_VECTOR 12
`define CTRL_INIT 13
`define CTRL_CLEAR 14
`define CTRL_INSTALL_LSB 10
`define TSEL_MAX 4'h8
`define TIME1_MAX 32'h0000_0064
`define FAN_DELAY_MAX 32'h0000_012C
`define AMBIENT_MIN 32'shFFFF_FFF6
`define AMBIENT_MAX 32'sh0000_0032
`define FUNC_TORQUE_1 5'h12
`define FUNC_TORQUE_2 5'h14
`define ANALOG_FUNC_LEVEL1 4'hB
`define IPL_CURRENT_PCT 8'h1E
`define OPL_CURRENT_PCT 8'h05
`define FAN_MODE_RUN 2'h0
`define FAN_MODE_POWER 2'h1
`define FAN_MODE_HEAT 2'h2
`define RATED_AMBIENT 8'h28
`define DERATE_STEP 8'h02
`define FULL_PCT 8'h64
`define OVERLOAD_CABINET 8'h96
`define OVERLOAD_SIDE 8'h8C
`define OVERLOAD_OUTSIDE 8'hA0
`define TICKS_PER_SECOND 12'h00A
`define TICK_MS 100
`define CLOCK_HZ 25000000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ### core/drive_protection_monitor.v
// Drive protection supervisor with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "drive_protection_monitor_regs.vh"
module drive_protection_monitor #(
  parameter TICK_CYCLES = (`CLOCK_HZ / 1000) * `TICK_MS
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Sensed drive quantities
  input wire run_cmd,
  input wire freq_agree,
  input wire decelerating,
  input wire [7:0] current_pct,
  input wire [7:0] torque_pct,
  input wire [23:0] phase_current_pct,
  input wire [3:0] analog_input_function,
  input wire [7:0] analog_level_pct,
  input wire supply_imbalance,
  input wire bus_cap_weak,
  input wire [2:0] ground_leakage,
  input wire heatsink_at_limit,
  // Protection outputs
  output reg overtorque_event,
  output reg undertorque_event,
  output reg torque_alarm,
  output reg torque_fault,
  output reg input_phase_loss_fault,
  output reg output_phase_loss_fault,
  output reg ground_fault_event,
  output reg drive_stop,
  output reg output_cutoff,
  output reg fan_on,
  output reg [3:0] terminal_out,
  output reg [7:0] current_limit_pct,
  output reg [7:0] overload_limit_pct
);

  function [31:0] merge_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
      merge_strb = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_strb[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  reg rst_s1_reg;
  reg rst_s2_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire srst_n = rst_s2_reg;

  // Sensed values come from another domain, so all pass two flops.
  localparam SW = 61;
  wire [SW-1:0] raw_in = {run_cmd, freq_agree, decelerating, current_pct,
    torque_pct, phase_current_pct, analog_input_function, analog_level_pct,
    supply_imbalance, bus_cap_weak, ground_leakage, heatsink_at_limit};
  reg [SW-1:0] meta_reg;
  reg [SW-1:0] sync_reg;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      meta_reg <= {SW{1'b0}};
      sync_reg <= {SW{1'b0}};
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end
  wire run_s = sync_reg[60];
  wire agree_s = sync_reg[59];
  wire decel_s = sync_reg[58];
  wire [7:0] cur_s = sync_reg[57:50];
  wire [7:0] trq_s = sync_reg[49:42];
  wire [23:0] phase_s = sync_reg[41:18];
  wire [3:0] afunc_s = sync_reg[17:14];
  wire [7:0] alevel_s = sync_reg[13:6];
  wire imbalance_s = sync_reg[5];
  wire capweak_s = sync_reg[4];
  wire [2:0] leak_s = sync_reg[3:1];
  wire heat_s = sync_reg[0];

  reg [31:0] ctrl_reg;
  reg [31:0] level_reg;
  reg [31:0] time1_reg;
  reg [31:0] fan_delay_reg;
  reg [31:0] ambient_reg;
  reg [31:0] terminals_reg;
  reg [31:0] status_word;
  reg [31:0] derate_word;

  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held_reg || aw_take;
  wire have_w = w_held_reg || w_take;
  wire [7:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_do = have_aw && have_w && !s_axi_bvalid;
  wire [31:0] ctrl_merged = merge_strb(ctrl_reg, wr_data, wr_strb);
  wire ctrl_wr = wr_do && (wr_addr == `ADDR_CTRL);
  wire init_cmd = ctrl_wr && ctrl_merged[`CTRL_INIT];
  wire clear_cmd = ctrl_wr && ctrl_merged[`CTRL_CLEAR];
  reg wr_ok;

  always @* begin
    case (wr_addr)
      `ADDR_CTRL, `ADDR_LEVEL, `ADDR_TIME1, `ADDR_FAN_DELAY,
      `ADDR_AMBIENT, `ADDR_TERMINALS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Out-of-range selector values are refused and the old setting stays.
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      ctrl_reg <= `CTRL_INIT_RST;
      level_reg <= `LEVEL_RST;
      time1_reg <= `TIME1_RST;
      fan_delay_reg <= `FAN_DELAY_RST;
      ambient_reg <= `AMBIENT_RST;
      terminals_reg <= `TERMINALS_RST;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_bvalid;
      s_axi_wready <= !have_w && !s_axi_bvalid;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
        case (wr_addr)
          `ADDR_CTRL: begin
            if (ctrl_merged[`CTRL_TSEL] <= `TSEL_MAX)
              ctrl_reg[`CTRL_TSEL] <= ctrl_merged[`CTRL_TSEL];
            ctrl_reg[`CTRL_IPL_EN] <= ctrl_merged[`CTRL_IPL_EN];
            if (ctrl_merged[`CTRL_OPL_SEL] != 2'h3)
              ctrl_reg[`CTRL_OPL_SEL] <= ctrl_merged[`CTRL_OPL_SEL];
            ctrl_reg[`CTRL_GF_EN] <= ctrl_merged[`CTRL_GF_EN];
            if (ctrl_merged[`CTRL_FAN_MODE] != 2'h3)
              ctrl_reg[`CTRL_FAN_MODE] <= ctrl_merged[`CTRL_FAN_MODE];
            if (ctrl_merged[`CTRL_INSTALL] != 2'h3)
              ctrl_reg[`CTRL_INSTALL] <= ctrl_merged[`CTRL_INSTALL];
            ctrl_reg[`CTRL_VECTOR] <= ctrl_merged[`CTRL_VECTOR];
          end
          `ADDR_LEVEL: level_reg <= merge_strb(level_reg, wr_data, wr_strb);
          `ADDR_TIME1: begin
            if (merge_strb(time1_reg, wr_data, wr_strb) <= `TIME1_MAX)
              time1_reg <= merge_strb(time1_reg, wr_data, wr_strb);
          end
          `ADDR_FAN_DELAY: begin
            if (merge_strb(fan_delay_reg, wr_data, wr_strb) <= `FAN_DELAY_MAX)
              fan_delay_reg <= merge_strb(fan_delay_reg, wr_data, wr_strb);
          end
          `ADDR_AMBIENT: begin
            if ($signed(merge_strb(ambient_reg, wr_data, wr_strb)) >=
                `AMBIENT_MIN && $signed(merge_strb(ambient_reg, wr_data,
                wr_strb)) <= `AMBIENT_MAX)
              ambient_reg <= merge_strb(ambient_reg, wr_data, wr_strb);
          end
          `ADDR_TERMINALS:
            terminals_reg <= merge_strb(terminals_reg, wr_data, wr_strb);
          default: ;
        endcase
        // Initialisation restores every setting except the install method.
        if (init_cmd) begin
          ctrl_reg <= `CTRL_INIT_RST;
          ctrl_reg[`CTRL_INSTALL] <= ctrl_reg[`CTRL_INSTALL];
          level_reg <= `LEVEL_RST;
          time1_reg <= `TIME1_RST;
          fan_delay_reg <= `FAN_DELAY_RST;
          ambient_reg <= `AMBIENT_RST;
          terminals_reg <= `TERMINALS_RST;
        end
      end
    end
  end

  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        case (s_axi_araddr)
          `ADDR_CTRL: s_axi_rdata <= ctrl_reg;
          `ADDR_LEVEL: s_axi_rdata <= level_reg;
          `ADDR_TIME1: s_axi_rdata <= time1_reg;
          `ADDR_FAN_DELAY: s_axi_rdata <= fan_delay_reg;
          `ADDR_AMBIENT: s_axi_rdata <= ambient_reg;
          `ADDR_TERMINALS: s_axi_rdata <= terminals_reg;
          `ADDR_STATUS: s_axi_rdata <= status_word;
          `ADDR_DERATE: s_axi_rdata <= derate_word;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // Tenth-of-a-second tick shared by the detection and fan timers.
  reg [31:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) tick_cnt_reg <= 32'h0000_0000;
    else tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h1;
  end

  wire [3:0] tsel = ctrl_reg[`CTRL_TSEL];
  wire tsel_on = (tsel != 4'h0) && (tsel <= `TSEL_MAX);
  wire tsel_under = (tsel > 4'h4);
  wire tsel_fault = (tsel == 4'h3) || (tsel == 4'h4) || (tsel == 4'h7) ||
    (tsel == 4'h8);
  wire [7:0] watched = ctrl_reg[`CTRL_VECTOR] ? trq_s : cur_s;
  wire [7:0] level1 = (afunc_s == `ANALOG_FUNC_LEVEL1) ? alevel_s :
    level_reg[7:0];
  wire window = tsel[0] ? (run_s && agree_s) : run_s;
  wire beyond = tsel_under ? (watched < level1) : (watched > level1);
  wire cond = tsel_on && window && beyond;
  reg [6:0] persist_reg;
  reg detect_reg;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      persist_reg <= 7'h00;
      detect_reg <= 1'b0;
    end else if (!cond) begin
      persist_reg <= 7'h00;
      detect_reg <= 1'b0;
    end else if (tick) begin
      if (persist_reg <= time1_reg[6:0]) persist_reg <= persist_reg + 7'h1;
      else detect_reg <= 1'b1;
    end
  end

  // Output phase loss is only judged while the drive is running.
  wire [2:0] phase_lost;
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      assign phase_lost[p] = run_s &&
        (phase_s[p*8 +: 8] < `OPL_CURRENT_PCT);
    end
  endgenerate
  wire [1:0] lost_count = {1'b0, phase_lost[0]} + {1'b0, phase_lost[1]} +
    {1'b0, phase_lost[2]};
  wire opl_hit = (ctrl_reg[`CTRL_OPL_SEL] == 2'h1 && lost_count >= 2'h1) ||
    (ctrl_reg[`CTRL_OPL_SEL] == 2'h2 && lost_count >= 2'h2);
  wire ipl_hit = ctrl_reg[`CTRL_IPL_EN] && (imbalance_s || capweak_s) &&
    run_s && !decel_s && (cur_s > `IPL_CURRENT_PCT);
  wire gf_hit = ctrl_reg[`CTRL_GF_EN] && (leak_s != 3'h0);

  // Faults latch until cleared; a new hit in the clear cycle survives.
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      overtorque_event <= 1'b0;
      undertorque_event <= 1'b0;
      torque_alarm <= 1'b0;
      torque_fault <= 1'b0;
      input_phase_loss_fault <= 1'b0;
      output_phase_loss_fault <= 1'b0;
      ground_fault_event <= 1'b0;
      drive_stop <= 1'b0;
      output_cutoff <= 1'b0;
    end else begin
      overtorque_event <= detect_reg && !tsel_under;
      undertorque_event <= detect_reg && tsel_under;
      torque_alarm <= detect_reg && !tsel_fault;
      torque_fault <= (detect_reg && tsel_fault) ||
        (torque_fault && !clear_cmd);
      input_phase_loss_fault <= ipl_hit ||
        (input_phase_loss_fault && !clear_cmd);
      output_phase_loss_fault <= opl_hit ||
        (output_phase_loss_fault && !clear_cmd);
      ground_fault_event <= gf_hit || (ground_fault_event && !clear_cmd);
      drive_stop <= (detect_reg && tsel_fault) || ipl_hit || opl_hit ||
        gf_hit || ((torque_fault || input_phase_loss_fault ||
        output_phase_loss_fault || ground_fault_event) && !clear_cmd);
      output_cutoff <= opl_hit ||
        (output_phase_loss_fault && !clear_cmd);
    end
  end

  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      terminal_out <= 4'h0;
    end else begin
      terminal_out <= 4'h0;
      terminal_out[0] <= detect_reg &&
        (terminals_reg[4:0] == `FUNC_TORQUE_1 ||
         terminals_reg[4:0] == `FUNC_TORQUE_2);
      terminal_out[1] <= detect_reg &&
        (terminals_reg[9:5] == `FUNC_TORQUE_1 ||
         terminals_reg[9:5] == `FUNC_TORQUE_2);
      terminal_out[2] <= detect_reg &&
        (terminals_reg[14:10] == `FUNC_TORQUE_1 ||
         terminals_reg[14:10] == `FUNC_TORQUE_2);
      terminal_out[3] <= detect_reg &&
        (terminals_reg[19:15] == `FUNC_TORQUE_1 ||
         terminals_reg[19:15] == `FUNC_TORQUE_2);
    end
  end

  reg [11:0] fan_cnt_reg;
  wire [11:0] fan_limit = fan_delay_reg[8:0] * `TICKS_PER_SECOND;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      fan_on <= 1'b0;
      fan_cnt_reg <= 12'h000;
    end else begin
      case (ctrl_reg[`CTRL_FAN_MODE])
        `FAN_MODE_RUN: begin
          if (run_s) begin
            fan_on <= 1'b1;
            fan_cnt_reg <= 12'h000;
          end else if (fan_cnt_reg >= fan_limit) begin
            fan_on <= 1'b0;
          end else if (tick) begin
            fan_cnt_reg <= fan_cnt_reg + 12'h001;
          end
        end
        `FAN_MODE_POWER: fan_on <= 1'b1;
        `FAN_MODE_HEAT: fan_on <= heat_s;
        default: fan_on <= 1'b0;
      endcase
    end
  end

  wire [7:0] amb = ambient_reg[7:0];
  wire amb_over = !amb[7] && (amb > `RATED_AMBIENT);
  wire [7:0] excess = amb - `RATED_AMBIENT;
  wire [7:0] derate = excess * `DERATE_STEP;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      current_limit_pct <= `FULL_PCT;
      overload_limit_pct <= `OVERLOAD_CABINET;
    end else begin
      current_limit_pct <= amb_over ? (`FULL_PCT - derate) : `FULL_PCT;
      case (ctrl_reg[`CTRL_INSTALL])
        2'h1: overload_limit_pct <= `OVERLOAD_SIDE;
        2'h2: overload_limit_pct <= `OVERLOAD_OUTSIDE;
        default: overload_limit_pct <= `OVERLOAD_CABINET;
      endcase
    end
  end

  always @* begin
    status_word = {22'h000000, fan_on, output_cutoff, drive_stop,
      ground_fault_event, output_phase_loss_fault, input_phase_loss_fault,
      torque_fault, torque_alarm, undertorque_event, overtorque_event};
    derate_word = {16'h0000, overload_limit_pct, current_limit_pct};
  end

endmodule // drive_protection_monitor

// ### tb/power_stage_model.sv
// Behavioural model of the power stage current and torque sensing.
`timescale 1ns/100ps
module power_stage_model (
  // Load and phase faults commanded by the bench
  input wire [7:0] load_pct,
  input wire [2:0] lost_ph,
  // Sensed quantities
  output logic [7:0] current_pct,
  output logic [7:0] torque_pct,
  output logic [23:0] phase_current_pct
);
  // A lost phase keeps a trickle just under the 5% line, not zero, so the
  // detector is exercised right at its threshold.
  // Torque reads a little above current so the method choice is visible.
  always_comb begin
    current_pct = load_pct;
    torque_pct = load_pct + 8'h0A;
    for (int i = 0; i < 3; i++)
      phase_current_pct[8*i +: 8] = lost_ph[i] ? 8'h04 : load_pct;
  end
endmodule // power_stage_model

// ### tb/drive_protection_monitor_props.sv
// Concurrent checks on the ports of the drive protection monitor.
`timescale 1ns/100ps
module drive_protection_monitor_props #(
  parameter TICK_CYCLES = 10
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register bus
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Drive side
  input wire run_cmd,
  input wire freq_agree,
  input wire decelerating,
  input wire [7:0] current_pct,
  input wire overtorque_event,
  input wire undertorque_event,
  input wire torque_alarm,
  input wire torque_fault,
  input wire input_phase_loss_fault,
  input wire output_phase_loss_fault,
  input wire ground_fault_event,
  input wire drive_stop,
  input wire output_cutoff
);
  reg [31:0] act_cnt_reg;
  reg [3:0] ipl_cnt_reg;
  wire ipl_ok = run_cmd && !decelerating && current_pct > 8'h1E;
  // Counts how long run_cmd or freq_agree has stayed high without a break.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt_reg <= 32'h0;
      ipl_cnt_reg <= 4'h0;
    end else begin
      act_cnt_reg <= (run_cmd || freq_agree) ? act_cnt_reg + 32'h1 : 32'h0;
      ipl_cnt_reg <= !ipl_ok ? 4'h0 : ipl_cnt_reg + {3'h0, ~&ipl_cnt_reg};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  chk_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_torque_persist: assert property (
    $rose(overtorque_event || undertorque_event) |->
    act_cnt_reg > TICK_CYCLES) else $error("torque event too early");
  chk_torque_kind: assert property (
    !(overtorque_event && undertorque_event)) else $error("both events");
  chk_alarm_cause: assert property (torque_alarm |->
    overtorque_event || undertorque_event ||
    $past(overtorque_event || undertorque_event))
    else $error("alarm without event");
  chk_fault_stops: assert property (
    torque_fault || input_phase_loss_fault || output_phase_loss_fault ||
    ground_fault_event |-> ##[0:1] drive_stop) else $error("no stop");
  chk_tfault_latch: assert property (
    $fell(run_cmd) && torque_fault |=> torque_fault [*3])
    else $error("torque fault not latched");
  chk_cutoff_opl: assert property (
    $rose(output_phase_loss_fault) |-> ##[0:1] output_cutoff)
    else $error("no cutoff");
  chk_ipl_gate: assert property (
    $rose(input_phase_loss_fault) |-> ipl_cnt_reg >= 4'h2)
    else $error("phase loss while masked");
  chk_gf_latch: assert property (
    $rose(ground_fault_event) |=> ground_fault_event [*4])
    else $error("ground fault not latched");
  cover property ($rose(overtorque_event));
  cover property ($rose(undertorque_event));
  cover property ($rose(output_phase_loss_fault));
endmodule // drive_protection_monitor_props
bind drive_protection_monitor drive_protection_monitor_props #(
  .TICK_CYCLES(TICK_CYCLES)) i_props (.*);

// ### tb/tb_drive_protection_monitor.sv
// Self-checking bench for the drive protection monitor.
`timescale 1ns/100ps
module tb_drive_protection_monitor;
  logic core_clk = 0, rst_n = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic run_cmd = 0, freq_agree = 0, decelerating = 0;
  logic supply_imbalance = 0, bus_cap_weak = 0, heatsink_at_limit = 0;
  logic [3:0] analog_input_function = 4'h0;
  logic [7:0] analog_level_pct = 8'h00, load_pct = 8'h00;
  logic [2:0] lost_ph = 3'h0, ground_leakage = 3'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] current_pct, torque_pct, current_limit_pct, overload_limit_pct;
  wire [23:0] phase_current_pct;
  wire overtorque_event, undertorque_event, torque_alarm, torque_fault;
  wire input_phase_loss_fault, output_phase_loss_fault, ground_fault_event;
  wire drive_stop, output_cutoff, fan_on;
  wire [3:0] terminal_out;
  wire [9:0] st = {fan_on, output_cutoff, drive_stop, ground_fault_event,
    output_phase_loss_fault, input_phase_loss_fault, torque_fault,
    torque_alarm, undertorque_event, overtorque_event};
  logic [9:0] exp_st;
  int err_count = 0, n_compared = 0;

  drive_protection_monitor #(.TICK_CYCLES(10)) i_dut (.*);
  power_stage_model i_model (.*);

  always #20 core_clk = ~core_clk;

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
      input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    chk("rdata", ex, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  task automatic wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (st[b] !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // Stops the drive, removes every cause and clears the latched faults.
  task automatic quiet(input logic [31:0] c);
    run_cmd <= 0;
    lost_ph <= 3'h0;
    supply_imbalance <= 0;
    bus_cap_weak <= 0;
    ground_leakage <= 3'h0;
    cyc(6);
    wr(8'h00, c | 32'h4000, 2'h0);
    cyc(4);
    chk("cleared", 32'h0, st[8:0]);
  endtask

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    cyc(6);
    rst_n <= 1;
    cyc(6);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h9696, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    rd(8'h0C, 32'h3C, 2'h0);
    rd(8'h10, 32'h28, 2'h0);
    rd(8'h1C, 32'h9664, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h1C, 32'h1, 2'h2);
    wr(8'h08, 32'h65, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    wr(8'h0C, 32'h12D, 2'h0);
    rd(8'h0C, 32'h3C, 2'h0);
    // Terminals 0 and 1 carry the two torque codes, terminal 2 a neighbour.
    wr(8'h14, 32'h4E92, 2'h0);
    // The stored level stays 150, so only the analog level can trip at 60.
    analog_input_function <= 4'hB;
    analog_level_pct <= 8'h32;
    for (int s = 1; s <= 8; s++) begin
      load_pct <= (s < 5) ? 8'h3C : 8'h14;
      freq_agree <= s[0];
      wr(8'h00, s, 2'h0);
      run_cmd <= 1;
      cyc(18);
      chk("early", 32'h0, st[8:0]);
      wait_st(s > 4, 1, 100);
      cyc(2);
      exp_st = (s < 5) ? 10'h201 : 10'h202;
      exp_st |= (((s - 1) % 4) < 2) ? 10'h004 : 10'h088;
      chk("status", exp_st, st);
      chk("terminals", 4'h3, terminal_out);
      quiet(s);
    end
    freq_agree <= 0;
    load_pct <= 8'h3C;
    wr(8'h00, 32'h1, 2'h0);
    run_cmd <= 1;
    cyc(80);
    chk("no agree", 32'h0, st[8:0]);
    wr(8'h00, 32'h6, 2'h0);
    repeat (6) begin
      load_pct <= 8'h14;
      cyc(15);
      load_pct <= 8'h3C;
      cyc(3);
    end
    chk("restart", 32'h0, st[8:0]);
    // Current stays under the level; only the torque reading is above it.
    load_pct <= 8'h2D;
    wr(8'h00, 32'h2, 2'h0);
    cyc(40);
    chk("current", 32'h0, st[8:0]);
    wr(8'h00, 32'h1002, 2'h0);
    wait_st(0, 1, 100);
    chk("torque", 10'h205, st);
    quiet(32'h0);
    wr(8'h00, 32'h10, 2'h0);
    run_cmd <= 1;
    load_pct <= 8'h1E;
    supply_imbalance <= 1;
    cyc(40);
    chk("ipl masked", 32'h0, st[8:0]);
    load_pct <= 8'h1F;
    supply_imbalance <= 0;
    bus_cap_weak <= 1;
    wait_st(4, 1, 20);
    chk("ipl", 10'h290, st);
    quiet(32'h10);
    for (int m = 1; m <= 2; m++) begin
      wr(8'h00, m << 5, 2'h0);
      run_cmd <= 1;
      lost_ph <= 3'h1;
      cyc(20);
      if (m == 2) begin
        chk("opl one", 32'h0, st[8:0]);
        lost_ph <= 3'h3;
      end
      wait_st(5, 1, 20);
      chk("opl", 10'h1A0, st[8:0]);
      quiet(m << 5);
    end
    ground_leakage <= 3'h2;
    cyc(20);
    chk("gf off", 32'h0, st[8:0]);
    wr(8'h00, 32'h80, 2'h0);
    wait_st(6, 1, 20);
    chk("gf", 10'h0C0, st[8:0]);
    quiet(32'h80);
    wr(8'h0C, 32'h1, 2'h0);
    run_cmd <= 1;
    cyc(6);
    chk("fan run", 1'h1, fan_on);
    run_cmd <= 0;
    cyc(60);
    chk("fan hold", 1'h1, fan_on);
    wait_st(9, 0, 100);
    chk("fan off", 1'h0, fan_on);
    wr(8'h00, 32'h100, 2'h0);
    cyc(4);
    chk("fan power", 1'h1, fan_on);
    wr(8'h00, 32'h200, 2'h0);
    cyc(4);
    chk("fan cool", 1'h0, fan_on);
    heatsink_at_limit <= 1;
    cyc(6);
    chk("fan hot", 1'h1, fan_on);
    wr(8'h10, 32'h2D, 2'h0);
    wr(8'h00, 32'h400, 2'h0);
    rd(8'h1C, 32'h8C5A, 2'h0);
    chk("limit", 8'h5A, current_limit_pct);
    wr(8'h00, 32'h800, 2'h0);
    wr(8'h00, 32'h2800, 2'h0);
    rd(8'h00, 32'h800, 2'h0);
    rd(8'h10, 32'h28, 2'h0);
    rd(8'h1C, 32'hA064, 2'h0);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule // tb_drive_protection_monitor
